// ==== rtc_timer_top.sv ====
// Real-time clock: source detect, tick divider, time counter, alarm and wake
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Count from main or low-power oscillator
// - Tick and every-n-ticks requests, each enabled
// - Whole chain forms a 58-bit timer
// - Wake from power-down when wake configured
// - Divider stepped by CPU clock over 64 or by low-power clock rising edges
// - Divider reloads prescale value every tick
// - Loadable 32-bit time counter counts ticks
// - Alarm request when time equals alarm
// - Tick, every-n-ticks and alarm requests wake the chip
// - Oscillator-off bit stops oscillator in power-down
// - Disabled block: both oscillators off in power-down
// - Low-power clock found: main oscillator off in power-down
// - No low-power clock: main kept unless disabled or oscillator-off bit set
// - All control reachable from the CPU side
module rtc_timer_top
   import rtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic lowpower_osc_input,
   input wire logic rtc_enable,
   input wire logic osc_off_in_powerdown,
   input wire logic powerdown_wake_cfg,
   input wire logic powerdown_req,
   input wire logic prescale_wr,
   input wire logic [DIV_W-1:0] prescale_wdata,
   input wire logic time_wr,
   input wire logic [TIME_W-1:0] time_wdata,
   input wire logic alarm_wr,
   input wire logic [TIME_W-1:0] alarm_wdata,
   input wire logic nticks_wr,
   input wire logic [NTICK_W-1:0] nticks_wdata,
   input wire logic tick_irq_en,
   input wire logic nticks_irq_en,
   input wire logic alarm_irq_en,
   output logic [TIME_W-1:0] time_count,
   output logic [TIMER_W-1:0] timer_chain,
   output logic tick_irq,
   output logic nticks_irq,
   output logic alarm_irq,
   output logic wake_req,
   output logic main_osc_enable,
   output logic lowpower_osc_enable,
   output logic lowpower_mode
);
   rtc_state_type state_reg, state_next;
   logic lp_sync1_reg, lp_sync2_reg, lp_sync3_reg;
   logic [DET_W-1:0] det_cnt_reg;
   logic [1:0] det_edges_reg;
   logic lp_mode_reg;
   logic [DIV_W-1:0] prescale_reg;
   logic [TIME_W-1:0] time_reg, time_next;
   logic [TIME_W-1:0] alarm_reg;
   logic [NTICK_W-1:0] nticks_reg;
   logic [NTICK_W-1:0] ncnt_reg, ncnt_next;
   logic match_reg;
   logic [TIMER_W-1:0] chain_reg;
   logic tick_irq_reg, nticks_irq_reg, alarm_irq_reg, wake_reg;
   logic main_on_reg, lp_on_reg;
   wire tick;
   wire lp_edge;
   wire in_pd;
   wire det_done;
   wire [NTICK_W-1:0] ncnt_plus1;
   wire nhit;
   wire match_now;
   wire alarm_evt;
   wire wake_evt;
   wire run;
   wire main_on_next;
   wire lp_on_next;

   rtc_div_if dif ();

   rtc_divider u_divider (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .dif(dif)
   );

   // ------------------------------------------------------------
   // Low-power oscillator sampling and detection
   // ------------------------------------------------------------
   assign lp_edge = lp_sync2_reg && !lp_sync3_reg;
   assign det_done = (state_reg == ST_DETECT) && (det_cnt_reg == DETECT_LAST);

   always_ff @(posedge clk_sys) begin
      lp_sync1_reg <= lowpower_osc_input;
      lp_sync2_reg <= lp_sync1_reg;
      lp_sync3_reg <= lp_sync2_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         det_cnt_reg <= '0;
         det_edges_reg <= '0;
         lp_mode_reg <= 1'b0;
      end else if (state_reg == ST_DETECT) begin
         det_cnt_reg <= det_cnt_reg + 1'b1;
         if (lp_edge && det_edges_reg != 2'h3) begin
            det_edges_reg <= det_edges_reg + 1'b1;
         end
         if (det_done) begin
            lp_mode_reg <= (det_edges_reg >= DETECT_MIN_EDGES);
         end
      end
   end

   // ------------------------------------------------------------
   // Operating state
   // ------------------------------------------------------------
   assign in_pd = (state_reg == ST_PDOWN);
   assign wake_evt = (tick && tick_irq_en) || (alarm_evt && alarm_irq_en)
      || (nhit && nticks_irq_en);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_DETECT: begin
            if (det_done) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (powerdown_req) begin
               state_next = ST_PDOWN;
            end
         end
         ST_PDOWN: begin
            if (!powerdown_req || (powerdown_wake_cfg && wake_evt)) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_DETECT;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Oscillator control and counting permission
   // ------------------------------------------------------------
   assign run = rtc_enable && ((state_reg == ST_RUN)
      || (in_pd && !(lp_mode_reg && osc_off_in_powerdown)));
   assign main_on_next = !in_pd
      || (!lp_mode_reg && rtc_enable && !osc_off_in_powerdown);
   assign lp_on_next = (state_reg == ST_DETECT)
      || (lp_mode_reg && rtc_enable && !(in_pd && osc_off_in_powerdown));

   assign dif.run = run;
   assign dif.lp_mode = lp_mode_reg;
   assign dif.lp_edge = lp_edge;
   assign dif.reload_val = prescale_reg;
   assign tick = dif.tick;

   // ------------------------------------------------------------
   // Time counter, alarm and n-tick counter
   // ------------------------------------------------------------
   assign time_next = time_wr ? time_wdata : (tick ? time_reg + 1'b1 : time_reg);
   assign match_now = (time_reg == alarm_reg);
   assign alarm_evt = match_now && !match_reg;
   assign ncnt_plus1 = ncnt_reg + 1'b1;
   assign nhit = tick && (nticks_reg != '0) && (ncnt_plus1 == nticks_reg);
   assign ncnt_next = nticks_wr ? '0 : (nhit ? '0 : (tick ? ncnt_plus1 : ncnt_reg));

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_reg <= ST_DETECT;
         prescale_reg <= PRESCALE_RST;
         time_reg <= TIME_RST;
         alarm_reg <= ALARM_RST;
         nticks_reg <= NTICK_RST;
         ncnt_reg <= '0;
         match_reg <= 1'b0;
         chain_reg <= '0;
         tick_irq_reg <= 1'b0;
         nticks_irq_reg <= 1'b0;
         alarm_irq_reg <= 1'b0;
         wake_reg <= 1'b0;
         main_on_reg <= 1'b1;
         lp_on_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         if (prescale_wr) begin
            prescale_reg <= prescale_wdata;
         end
         if (alarm_wr) begin
            alarm_reg <= alarm_wdata;
         end
         if (nticks_wr) begin
            nticks_reg <= nticks_wdata;
         end
         time_reg <= time_next;
         ncnt_reg <= ncnt_next;
         match_reg <= match_now;
         chain_reg <= {time_reg, dif.div_count, dif.pre_count};
         tick_irq_reg <= tick && tick_irq_en;
         nticks_irq_reg <= nhit && nticks_irq_en;
         alarm_irq_reg <= alarm_evt && alarm_irq_en;
         wake_reg <= in_pd && powerdown_wake_cfg && wake_evt;
         main_on_reg <= main_on_next;
         lp_on_reg <= lp_on_next;
      end
   end

   assign time_count = time_reg;
   assign timer_chain = chain_reg;
   assign tick_irq = tick_irq_reg;
   assign nticks_irq = nticks_irq_reg;
   assign alarm_irq = alarm_irq_reg;
   assign wake_req = wake_reg;
   assign main_osc_enable = main_on_reg;
   assign lowpower_osc_enable = lp_on_reg;
   assign lowpower_mode = lp_mode_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_tick_irq_pulse: assert property (tick_irq |=> !tick_irq)
      else $error("Tick request longer than one cycle");
   a_tick_irq_gate: assert property (tick_irq |-> $past(tick_irq_en) && $past(tick))
      else $error("Tick request without enabled tick");
   a_time_increment: assert property ((tick && !time_wr) |=>
      time_reg == $past(time_reg) + 1)
      else $error("Time counter missed a tick");
   a_time_load_wins: assert property (time_wr |=> time_reg == $past(time_wdata))
      else $error("Time write lost");
   a_alarm_on_match: assert property ((alarm_evt && alarm_irq_en) |=> alarm_irq)
      else $error("Alarm match without request");
   a_alarm_cause: assert property (alarm_irq |-> $past(time_reg == alarm_reg))
      else $error("Alarm request without match");
   a_chain_value: assert property (##1 timer_chain ==
      $past({time_reg, dif.div_count, dif.pre_count}))
      else $error("Timer chain mismatch");
   a_wake_needs_cfg: assert property (wake_req |-> $past(powerdown_wake_cfg && in_pd))
      else $error("Wake without configuration");
   a_disabled_all_off: assert property ((in_pd && !rtc_enable)[*2] |->
      !main_osc_enable && !lowpower_osc_enable)
      else $error("Oscillator left on while disabled");
   a_lp_main_off: assert property ((in_pd && lp_mode_reg)[*2] |-> !main_osc_enable)
      else $error("Main oscillator on in low-power mode");
   a_osc_off_stop: assert property ((in_pd && osc_off_in_powerdown)[*2] |->
      !lowpower_osc_enable && !main_osc_enable)
      else $error("Oscillator running despite off bit");

   c_tick_irq: cover property (tick_irq);
   c_nticks_irq: cover property (nticks_irq);
   c_alarm_irq: cover property (alarm_irq);
   c_wake: cover property (wake_req ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

// ==== rtc_pkg.sv ====
// Constants and types shared by the real-time clock block
package rtc_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PREDIV_W = 6;
   localparam int DIV_W = 20;
   localparam int TIME_W = 32;
   localparam int TIMER_W = 58;
   localparam int NTICK_W = 16;
   localparam int DET_W = 12;
   // ------------------------------------------------------------
   // Counts and timing
   // ------------------------------------------------------------
   localparam int PREDIV_RATIO = 64;
   localparam logic [PREDIV_W-1:0] PREDIV_LAST = PREDIV_W'(PREDIV_RATIO - 1);
   localparam int CLK_FREQ_MHZ = 40;
   localparam int DETECT_WINDOW_US = 100;
   localparam int DETECT_CYCLES = DETECT_WINDOW_US * CLK_FREQ_MHZ;
   localparam logic [DET_W-1:0] DETECT_LAST = DET_W'(DETECT_CYCLES - 1);
   localparam logic [1:0] DETECT_MIN_EDGES = 2'h2;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [DIV_W-1:0] PRESCALE_RST = 20'h0_0000;
   localparam logic [TIME_W-1:0] TIME_RST = 32'h0000_0000;
   localparam logic [TIME_W-1:0] ALARM_RST = 32'hFFFF_FFFF;
   localparam logic [NTICK_W-1:0] NTICK_RST = 16'h0000;
   // ------------------------------------------------------------
   // Operating states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_DETECT = 2'h0,
      ST_RUN = 2'h1,
      ST_PDOWN = 2'h3
   } rtc_state_type;
endpackage

// ==== rtc_div_if.sv ====
// Link between the timer control and the tick divider
`timescale 1ns/1ps
`default_nettype none
interface rtc_div_if;
   import rtc_pkg::*;
   logic run;
   logic lp_mode;
   logic lp_edge;
   logic [DIV_W-1:0] reload_val;
   logic tick;
   logic [PREDIV_W-1:0] pre_count;
   logic [DIV_W-1:0] div_count;
   modport ctrl (output run, output lp_mode, output lp_edge, output reload_val,
      input tick, input pre_count, input div_count);
   modport div (input run, input lp_mode, input lp_edge, input reload_val,
      output tick, output pre_count, output div_count);
endinterface
`default_nettype wire

// ==== rtc_divider.sv ====
// Fixed pre-divider and reloadable tick divider
`timescale 1ns/1ps
`default_nettype none
module rtc_divider
   import rtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   rtc_div_if.div dif
);
   logic [PREDIV_W-1:0] pre_reg;
   logic [PREDIV_W-1:0] pre_next;
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_next;
   logic tick_reg;
   logic tick_next;
   wire pre_wrap;
   wire step;
   wire div_zero;

   // ------------------------------------------------------------
   // Step selection and count down
   // ------------------------------------------------------------
   assign pre_wrap = (pre_reg == PREDIV_LAST);
   assign step = dif.run && (dif.lp_mode ? dif.lp_edge : pre_wrap);
   assign div_zero = (div_reg == '0);
   assign pre_next = (dif.run && !dif.lp_mode) ? pre_reg + 1'b1 : pre_reg;
   assign div_next = !step ? div_reg : (div_zero ? dif.reload_val : div_reg - 1'b1);
   assign tick_next = step && div_zero;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pre_reg <= '0;
         div_reg <= PRESCALE_RST;
         tick_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         div_reg <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign dif.tick = tick_reg;
   assign dif.pre_count = pre_reg;
   assign dif.div_count = div_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_div_reload_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tick_reg |-> div_reg == $past(dif.reload_val))
      else $error("Divider not reloaded on tick");
   a_prediv_wrap_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (pre_reg == PREDIV_LAST && dif.run && !dif.lp_mode) |=> pre_reg == '0)
      else $error("Pre-divider did not wrap at 64");
endmodule
`default_nettype wire

// ==== rtc_cpu_model.sv ====
// CPU-side write model and low-power oscillator source for the clock block
`timescale 1ns/1ps
`default_nettype none
module rtc_cpu_model
   import rtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic lp_run,
   output logic lowpower_osc_input,
   output logic prescale_wr,
   output logic [DIV_W-1:0] prescale_wdata,
   output logic time_wr,
   output logic [TIME_W-1:0] time_wdata,
   output logic alarm_wr,
   output logic [TIME_W-1:0] alarm_wdata,
   output logic nticks_wr,
   output logic [NTICK_W-1:0] nticks_wdata
);
   initial begin
      {lowpower_osc_input, prescale_wr, time_wr, alarm_wr, nticks_wr} = 5'h00;
      {prescale_wdata, nticks_wdata} = 36'h0_0000_0000;
      {time_wdata, alarm_wdata} = 64'h0000_0000_0000_0000;
   end
   // 32 kHz crystal, stands low while stopped
   always #15625 lowpower_osc_input = lp_run ? ~lowpower_osc_input : 1'b0;
   // One-cycle write strobe; idle data lines show the inverse value
   task automatic wr(input int sel, input logic [31:0] d);
      @(negedge clk_sys);
      prescale_wdata = d[DIV_W-1:0];
      time_wdata = d;
      alarm_wdata = d;
      nticks_wdata = d[NTICK_W-1:0];
      prescale_wr = (sel == 0);
      time_wr = (sel == 1);
      alarm_wr = (sel == 2);
      nticks_wr = (sel == 3);
      @(negedge clk_sys);
      {prescale_wr, time_wr, alarm_wr, nticks_wr} = 4'h0;
      {prescale_wdata, nticks_wdata} = ~{prescale_wdata, nticks_wdata};
      {time_wdata, alarm_wdata} = ~{time_wdata, alarm_wdata};
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the real-time clock block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rtc_pkg::*;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic clk_sys, reset_n, lp_run, rtc_enable, osc_off, wake_cfg, pd_req, t_en, n_en, a_en;
   logic lp_in, p_wr, t_wr, a_wr, n_wr, tick_irq, nticks_irq, alarm_irq, wake_req;
   logic main_en, lp_en, lp_mode;
   logic [DIV_W-1:0] p_d;
   logic [TIME_W-1:0] t_d, a_d, time_count;
   logic [NTICK_W-1:0] n_d;
   logic [TIMER_W-1:0] chain;
   logic [31:0] time_q[$], gap_q[$], alarm_q[$], nt_q[$];
   int error_cnt, samples_checked, cyc, last_tick, nt_cnt, p, t0, k;
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   rtc_cpu_model cpu_u (.clk_sys(clk_sys), .lp_run(lp_run), .lowpower_osc_input(lp_in),
      .prescale_wr(p_wr), .prescale_wdata(p_d), .time_wr(t_wr), .time_wdata(t_d),
      .alarm_wr(a_wr), .alarm_wdata(a_d), .nticks_wr(n_wr), .nticks_wdata(n_d));
   rtc_timer_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .lowpower_osc_input(lp_in),
      .rtc_enable(rtc_enable), .osc_off_in_powerdown(osc_off), .powerdown_wake_cfg(wake_cfg),
      .powerdown_req(pd_req), .prescale_wr(p_wr), .prescale_wdata(p_d), .time_wr(t_wr),
      .time_wdata(t_d), .alarm_wr(a_wr), .alarm_wdata(a_d), .nticks_wr(n_wr),
      .nticks_wdata(n_d), .tick_irq_en(t_en), .nticks_irq_en(n_en), .alarm_irq_en(a_en),
      .time_count(time_count), .timer_chain(chain), .tick_irq(tick_irq),
      .nticks_irq(nticks_irq), .alarm_irq(alarm_irq), .wake_req(wake_req),
      .main_osc_enable(main_en), .lowpower_osc_enable(lp_en), .lowpower_mode(lp_mode));
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      samples_checked++;
      if (e !== g) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wait_hi(ref logic s, input string nm);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (s !== 1'b1 && n < 6000);
      if (n >= 6000) chk(nm, 1, 0);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 40000) begin
         error_cnt++;
         close_out();
      end
      if (tick_irq === 1'b1) begin
         if (time_q.size() > 0) chk("time_count", time_q.pop_front(), time_count);
         if (gap_q.size() > 0) chk("tick_gap", gap_q.pop_front(), cyc - last_tick);
         last_tick = cyc;
         nt_cnt++;
      end
      if (nticks_irq === 1'b1) begin
         if (nt_q.size() > 0) chk("nticks_gap", nt_q.pop_front(), nt_cnt);
         nt_cnt = 0;
      end
      if (alarm_irq === 1'b1 && alarm_q.size() > 0) begin
         chk("alarm_time", alarm_q.pop_front(), time_count);
      end
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h0c50));
      {reset_n, lp_run, osc_off, wake_cfg, pd_req} = 5'h00;
      {rtc_enable, t_en, n_en, a_en} = 4'hf;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      chk("time_count", 0, time_count);
      chk("main_osc_enable", 1, main_en);
      repeat (4100) @(negedge clk_sys);
      chk("lowpower_mode", 0, lp_mode);
      $display("Test reset done");
      for (int i = 0; i < 2; i++) begin
         p = $urandom_range(3);
         cpu_u.wr(0, p);
         wait_hi(tick_irq, "tick_irq");
         wait_hi(tick_irq, "tick_irq");
         repeat (2) gap_q.push_back(64 * (p + 1));
         repeat (2) wait_hi(tick_irq, "tick_irq");
      end
      $display("Test prescale done");
      t0 = $urandom & 32'h0fff_ffff;
      cpu_u.wr(2, t0 + 3);
      cpu_u.wr(1, t0);
      for (int i = 1; i < 4; i++) time_q.push_back(t0 + i);
      alarm_q.push_back(t0 + 3);
      repeat (3) wait_hi(tick_irq, "tick_irq");
      repeat (4) @(negedge clk_sys);
      chk("timer_chain", t0 + 3, chain[TIMER_W-1:TIMER_W-TIME_W]);
      $display("Test time and alarm done");
      wait_hi(tick_irq, "tick_irq");
      cpu_u.wr(3, 3);
      nt_cnt = 0;
      repeat (2) nt_q.push_back(3);
      repeat (2) wait_hi(nticks_irq, "nticks_irq");
      {t_en, n_en} = 2'h0;
      k = 0;
      repeat (1100) begin
         @(negedge clk_sys);
         k += (tick_irq === 1'b1 || nticks_irq === 1'b1);
      end
      chk("disabled_pulses", 0, k);
      {t_en, n_en} = 2'h3;
      $display("Test n-tick done");
      wake_cfg = 1'b1;
      pd_req = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("main_osc_enable", 1, main_en);
      chk("lowpower_osc_enable", 0, lp_en);
      wait_hi(wake_req, "wake_req");
      {pd_req, wake_cfg, osc_off} = 3'h1;
      @(negedge clk_sys);
      pd_req = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("main_osc_enable", 0, main_en);
      {pd_req, osc_off, rtc_enable} = 3'h0;
      @(negedge clk_sys);
      pd_req = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("main_osc_enable", 0, main_en);
      chk("lowpower_osc_enable", 0, lp_en);
      {pd_req, rtc_enable} = 2'h1;
      $display("Test power-down done");
      lp_run = 1'b1;
      reset_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (4100) @(negedge clk_sys);
      chk("lowpower_mode", 1, lp_mode);
      wait_hi(tick_irq, "tick_irq");
      pd_req = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("main_osc_enable", 0, main_en);
      chk("lowpower_osc_enable", 1, lp_en);
      pd_req = 1'b0;
      chk("pending", 0, time_q.size() + gap_q.size() + alarm_q.size() + nt_q.size());
      $display("Test low-power done");
      close_out();
   end
endmodule
`default_nettype wire
